// ===== logic/flash_status_partition_regs.sv
// Per-partition status words, extended status and partition configuration
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module flash_status_partition_regs #(
    parameter int NUM_PART = 4,
    parameter bit TOP_PARAM = 1'b0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire flash_status_pkg::ctrl_event_t ctrl_evt,
    input wire logic pb_opcode_seen,
    input wire logic pb_free,
    output logic [NUM_PART-1:0] partition_ready,
    output flash_status_pkg::plane_map_t plane_map
);

    // The address map and the mapping decode are built for four planes
    if (NUM_PART != 4) begin : g_bad_part
        $error("flash_status_partition_regs: NUM_PART must be 4");
    end

    ////////////////////////////////////////////////////////////////////////
    // Notes for integrators
    //
    // Register port
    // - Index 0 to 3 reads the status word of partitions 0 to 3.
    // - Index 4 reads the extended status word.
    // - Index 5 reads and writes the partition configuration word.
    // - Index 6 is write-only control; bit 0 set clears error flags.
    // - Any other index reads as zero and ignores writes.
    // - Read data appear one cycle after the read strobe, then return
    //   to zero, so a bus OR of several slaves stays clean.
    // - Writes to status and extended status words are dropped.
    // - A read and a write in the same cycle are not expected; the
    //   write still lands and the read still answers.
    //
    // Read multiplexer
    // - The word is chosen by index in the cycle of the strobe.
    // - Data are captured at that edge and shown for one cycle.
    // - Without a strobe the output is forced back to zero.
    //
    // Controller events
    // - Every event names a partition and an operation class.
    // - Start marks an accepted sequence; the partition goes busy.
    // - Done marks the end; the partition goes ready again.
    // - Failure is reported with done and picks the flag by class.
    // - Suspend and resume only touch the flag of their own class.
    // - Done also drops a stale suspend flag of its class.
    // - Resume wins over suspend if both arrive in one cycle.
    // - Start wins over done if both arrive in one cycle.
    //
    // Aborts at start
    // - Supply level is only looked at when a sequence starts.
    // - Word programs do not look at the supply level.
    // - Lock state is looked at for erase and program classes.
    // - An aborted start leaves the partition ready.
    // - Both abort reasons may be flagged by one start.
    //
    // Error flags
    // - Error flags are sticky until the clear command.
    // - A new error in the clear cycle survives the clear.
    // - A malformed sequence raises both erase and program errors.
    // - The clear acts on every partition at once.
    // - Ready and suspend flags are not touched by the clear.
    //
    // Hazards
    // - Ready is per partition; the shared write controller may be
    //   busy for another partition while this one reads ready.
    // - Software must not trust bits 6 to 1 while bit 7 is zero.
    // - Reserved bits read zero here, but software should still
    //   mask them, since later revisions may use them.
    // - Extended bit 7 reflects the last opcode attempt only; it
    //   does not follow the buffer level between attempts.
    // - Rejected attempts must be repeated to see a freed buffer.
    //
    // Partition configuration
    // - Only bits 10 to 8 are stored; the rest read zero.
    // - Reset loads the variant default chosen by TOP_PARAM.
    // - The plane map lags the field by one cycle, because it is
    //   decoded from the stored field and registered again.
    // - Partition ids count upward from plane 0.
    // - Code 000 puts all planes in partition 0, without dual work.
    // - Every other code allows dual work between partitions.
    // - Changing the field while operations run is not guarded;
    //   the array side must only honour it when all are ready.
    //
    // Reset
    // - Reset is synchronous and active high.
    // - After reset every status word reads ready with no flags.
    // - Extended status reads the buffer as available.
    // - The first access may follow in the first cycle out of reset.
    //
    // Timing
    // - No path here spans more than one flip-flop stage between
    //   a port and a register, apart from the read multiplexer and the plane map.
    // - All outputs come straight from flip-flops.
    // - There are no counters and no long waits in this block.
    //
    // Parameters
    // - NUM_PART must be 4; the map and decode assume four planes.
    // - TOP_PARAM selects the reset code of the configuration field.
    // - Other values of NUM_PART stop elaboration with an error.
    //
    // Limits
    // - Only one event is taken per cycle, for one partition.
    // - The block does not decode command opcodes itself.
    // - Lock state and supply level come in on the event word.
    // - No interrupt is raised; software polls the words.
    //
    // Field encoding of the status word
    // - Bit 7 ready, bit 6 erase suspended, bit 5 erase error.
    // - Bit 4 program error, bit 3 supply low, bit 2 program
    //   suspended, bit 1 locked block violation.
    // - Bit 0 and bits 15 to 8 are reserved and read zero.
    //
    // Extended status and configuration encoding
    // - Extended bit 7 holds page buffer availability.
    // - Configuration bits 10 to 8 hold the plane grouping field.
    // - All other bits of both words are reserved and read zero.

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Expand a configuration code into the plane map
    function automatic flash_status_pkg::plane_map_t decode_planes(
        input logic [2:0] code
    );
        flash_status_pkg::plane_map_t m;
        m = '0;
        unique case (code)
            3'h0: begin
                m.part_count = 3'h1;
            end
            3'h1: begin
                m = '{plane3: 2'h1, plane2: 2'h1, plane1: 2'h1, plane0: 2'h0,
                      part_count: 3'h2, dual_work: 1'b1};
            end
            3'h2: begin
                m = '{plane3: 2'h1, plane2: 2'h1, plane1: 2'h0, plane0: 2'h0,
                      part_count: 3'h2, dual_work: 1'b1};
            end
            3'h4: begin
                m = '{plane3: 2'h1, plane2: 2'h0, plane1: 2'h0, plane0: 2'h0,
                      part_count: 3'h2, dual_work: 1'b1};
            end
            3'h3: begin
                m = '{plane3: 2'h2, plane2: 2'h2, plane1: 2'h1, plane0: 2'h0,
                      part_count: 3'h3, dual_work: 1'b1};
            end
            3'h6: begin
                m = '{plane3: 2'h2, plane2: 2'h1, plane1: 2'h0, plane0: 2'h0,
                      part_count: 3'h3, dual_work: 1'b1};
            end
            3'h5: begin
                m = '{plane3: 2'h2, plane2: 2'h1, plane1: 2'h1, plane0: 2'h0,
                      part_count: 3'h3, dual_work: 1'b1};
            end
            3'h7: begin
                m = '{plane3: 2'h3, plane2: 2'h2, plane1: 2'h1, plane0: 2'h0,
                      part_count: 3'h4, dual_work: 1'b1};
            end
        endcase
        return m;
    endfunction : decode_planes

    // Erase-class operations report into the erase flags
    function automatic logic is_erase(input flash_status_pkg::op_kind_t k);
        return (k == flash_status_pkg::OP_ERASE) || (k == flash_status_pkg::OP_FULL_ERASE);
    endfunction : is_erase

    // Program-class operations report into the program flags
    function automatic logic is_program(input flash_status_pkg::op_kind_t k);
        return (k == flash_status_pkg::OP_PROGRAM) || (k == flash_status_pkg::OP_PAGE_PROGRAM)
            || (k == flash_status_pkg::OP_OTP_PROGRAM);
    endfunction : is_program

    // Operations at whose start the supply level is interrogated
    function automatic logic checks_supply(input flash_status_pkg::op_kind_t k);
        return is_erase(k) || (k == flash_status_pkg::OP_PAGE_PROGRAM)
            || (k == flash_status_pkg::OP_OTP_PROGRAM);
    endfunction : checks_supply

    ////////////////////////////////////////////////////////////////////////
    // Register port strobes

    logic clear_req;
    logic pcr_wr;
    logic [2:0] pcr_field_r;
    logic pb_avail_r;
    logic [15:0] status_word [NUM_PART];

    // Dedicated clear command and configuration write
    assign clear_req = reg_wr && (reg_addr == flash_status_pkg::ADDR_CONTROL)
        && reg_wdata[flash_status_pkg::CTRL_CLEAR_STATUS];
    assign pcr_wr = reg_wr && (reg_addr == flash_status_pkg::ADDR_PART_CONFIG);

    ////////////////////////////////////////////////////////////////////////
    // Per-partition status words

    for (genvar p = 0; p < NUM_PART; p++) begin : g_part
        logic hit;
        logic ready_r;
        logic erase_susp_r;
        logic erase_err_r;
        logic prog_err_r;
        logic supply_low_r;
        logic prog_susp_r;
        logic lock_viol_r;
        logic abort_supply;
        logic abort_lock;
        logic set_erase_err;
        logic set_prog_err;

        assign hit = (ctrl_evt.part == 2'(p));
        // Supply and lock are interrogated only when a sequence starts
        assign abort_supply = hit && ctrl_evt.start && checks_supply(ctrl_evt.kind)
            && ctrl_evt.supply_low;
        assign abort_lock = hit && ctrl_evt.start
            && (is_erase(ctrl_evt.kind) || is_program(ctrl_evt.kind))
            && ctrl_evt.block_locked;
        // Failure at completion, or a malformed sequence, raises error flags
        assign set_erase_err = hit && ((ctrl_evt.done && ctrl_evt.op_fail
            && is_erase(ctrl_evt.kind)) || ctrl_evt.seq_error);
        assign set_prog_err = hit && ((ctrl_evt.done && ctrl_evt.op_fail
            && is_program(ctrl_evt.kind)) || ctrl_evt.seq_error);

        // Ready clears on an accepted start, sets on completion; an aborted start leaves it unchanged
        always_ff @(posedge core_clk) begin
            if (srst) begin
                ready_r <= 1'b1;
            end else if (hit && ctrl_evt.start && !abort_supply && !abort_lock) begin
                ready_r <= 1'b0;
            end else if (hit && ctrl_evt.done) begin
                ready_r <= 1'b1;
            end
        end

        // Suspend flags follow suspend and resume of the running operation
        always_ff @(posedge core_clk) begin
            if (srst) begin
                erase_susp_r <= 1'b0;
                prog_susp_r <= 1'b0;
            end else if (hit && (ctrl_evt.resume || ctrl_evt.done)) begin
                if (is_erase(ctrl_evt.kind)) begin
                    erase_susp_r <= 1'b0;
                end
                if (is_program(ctrl_evt.kind)) begin
                    prog_susp_r <= 1'b0;
                end
            end else if (hit && ctrl_evt.suspend) begin
                if (is_erase(ctrl_evt.kind)) begin
                    erase_susp_r <= 1'b1;
                end
                if (is_program(ctrl_evt.kind)) begin
                    prog_susp_r <= 1'b1;
                end
            end
        end

        // Sticky error flags; a set in the clear cycle wins
        always_ff @(posedge core_clk) begin
            if (srst) begin
                erase_err_r <= 1'b0;
                prog_err_r <= 1'b0;
                supply_low_r <= 1'b0;
                lock_viol_r <= 1'b0;
            end else begin
                erase_err_r <= set_erase_err || (erase_err_r && !clear_req);
                prog_err_r <= set_prog_err || (prog_err_r && !clear_req);
                supply_low_r <= abort_supply || (supply_low_r && !clear_req);
                lock_viol_r <= abort_lock || (lock_viol_r && !clear_req);
            end
        end

        // Assemble the word; reserved bits are zero
        always_comb begin
            status_word[p] = 16'h0000;
            status_word[p][flash_status_pkg::SR_READY] = ready_r;
            status_word[p][flash_status_pkg::SR_ERASE_SUSP] = erase_susp_r;
            status_word[p][flash_status_pkg::SR_ERASE_ERR] = erase_err_r;
            status_word[p][flash_status_pkg::SR_PROG_ERR] = prog_err_r;
            status_word[p][flash_status_pkg::SR_SUPPLY_LOW] = supply_low_r;
            status_word[p][flash_status_pkg::SR_PROG_SUSP] = prog_susp_r;
            status_word[p][flash_status_pkg::SR_LOCK_VIOL] = lock_viol_r;
        end

        assign partition_ready[p] = ready_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Extended status: page buffer availability

    // Latched on each page program opcode, accepted when the buffer is free
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pb_avail_r <= flash_status_pkg::PB_AVAIL_RESET;
        end else if (pb_opcode_seen) begin
            pb_avail_r <= pb_free;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partition configuration

    // Field loads the variant default at reset, software may rewrite it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pcr_field_r <= TOP_PARAM ? flash_status_pkg::PCR_RESET_TOP
                                     : flash_status_pkg::PCR_RESET_BOTTOM;
        end else if (pcr_wr) begin
            pcr_field_r <= reg_wdata[flash_status_pkg::PCR_FIELD_MSB:
                                     flash_status_pkg::PCR_FIELD_LSB];
        end
    end

    // Registered plane map for the array side
    always_ff @(posedge core_clk) begin
        if (srst) begin
            plane_map <= decode_planes(TOP_PARAM ? flash_status_pkg::PCR_RESET_TOP
                                                 : flash_status_pkg::PCR_RESET_BOTTOM);
        end else begin
            plane_map <= decode_planes(pcr_field_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: valid only in the cycle after the read strobe

    always_ff @(posedge core_clk) begin
        if (srst || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_addr)
                flash_status_pkg::ADDR_STATUS_P0: reg_rdata <= status_word[0];
                flash_status_pkg::ADDR_STATUS_P1: reg_rdata <= status_word[1];
                flash_status_pkg::ADDR_STATUS_P2: reg_rdata <= status_word[2];
                flash_status_pkg::ADDR_STATUS_P3: reg_rdata <= status_word[3];
                flash_status_pkg::ADDR_EXT_STATUS: begin
                    reg_rdata <= {8'h00, pb_avail_r, 7'h00};
                end
                flash_status_pkg::ADDR_PART_CONFIG: begin
                    reg_rdata <= {5'h00, pcr_field_r, 8'h00};
                end
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

endmodule : flash_status_partition_regs

`default_nettype wire

// ===== logic/flash_status_pkg.sv
// Package: register map, field positions, reset values and carrier types
package flash_status_pkg;

    // Register word indices on the register port
    localparam logic [3:0] ADDR_STATUS_P0 = 4'h0;
    localparam logic [3:0] ADDR_STATUS_P1 = 4'h1;
    localparam logic [3:0] ADDR_STATUS_P2 = 4'h2;
    localparam logic [3:0] ADDR_STATUS_P3 = 4'h3;
    localparam logic [3:0] ADDR_EXT_STATUS = 4'h4;
    localparam logic [3:0] ADDR_PART_CONFIG = 4'h5;
    localparam logic [3:0] ADDR_CONTROL = 4'h6;

    // Status word bit positions
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_SUPPLY_LOW = 3;
    localparam int SR_PROG_SUSP = 2;
    localparam int SR_LOCK_VIOL = 1;

    // Extended status and configuration field positions
    localparam int XSR_PB_AVAIL = 7;
    localparam int PCR_FIELD_LSB = 8;
    localparam int PCR_FIELD_MSB = 10;

    // Control word bit: clear status flags of every partition
    localparam int CTRL_CLEAR_STATUS = 0;

    // Reset values
    localparam logic PB_AVAIL_RESET = 1'b1;
    localparam logic [2:0] PCR_RESET_BOTTOM = 3'h1;
    localparam logic [2:0] PCR_RESET_TOP = 3'h4;

    // Operation classes reported by the internal write controller
    typedef enum logic [2:0] {
        OP_ERASE,
        OP_FULL_ERASE,
        OP_PROGRAM,
        OP_PAGE_PROGRAM,
        OP_OTP_PROGRAM,
        OP_LOCK_CONFIG
    } op_kind_t;

    // One event from the internal write controller
    typedef struct packed {
        logic start;
        logic done;
        logic suspend;
        logic resume;
        logic seq_error;
        logic op_fail;
        logic supply_low;
        logic block_locked;
        logic [1:0] part;
        op_kind_t kind;
    } ctrl_event_t;

    // Plane to partition mapping produced by the configuration field
    typedef struct packed {
        logic [1:0] plane3;
        logic [1:0] plane2;
        logic [1:0] plane1;
        logic [1:0] plane0;
        logic [2:0] part_count;
        logic dual_work;
    } plane_map_t;

endpackage : flash_status_pkg

// ===== dv/flash_status_props.sv
// Concurrent checks on the status and partition register block ports
`timescale 1ns/1ps
`default_nettype none
module flash_status_props #(
    parameter int NUM_PART = 4,
    parameter bit TOP_PARAM = 1'b0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire flash_status_pkg::ctrl_event_t ctrl_evt,
    input wire logic pb_opcode_seen,
    input wire logic pb_free,
    input wire logic [NUM_PART-1:0] partition_ready,
    input wire flash_status_pkg::plane_map_t plane_map
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    // Read port answers only in the cycle after a read
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    ready_read_a: assert property (reg_rd && reg_addr == 4'h0 |=>
        reg_rdata[7] == $past(partition_ready[0])) else $error("ready bit mismatch");
    // Ready follows controller start and done
    busy_start_a: assert property (ctrl_evt.start && !ctrl_evt.supply_low &&
        !ctrl_evt.block_locked |=> !partition_ready[$past(ctrl_evt.part)])
        else $error("partition not busy after start");
    ready_done_a: assert property (ctrl_evt.done |=>
        partition_ready[$past(ctrl_evt.part)]) else $error("partition not ready after done");
    own_word_a: assert property (ctrl_evt.start && ctrl_evt.part == 2'h1 |=>
        $stable({partition_ready[3:2], partition_ready[0]})) else $error("other ready moved");
    supply_abort_a: assert property (ctrl_evt.start && ctrl_evt.supply_low &&
        ctrl_evt.kind == flash_status_pkg::OP_PAGE_PROGRAM |=>
        partition_ready[$past(ctrl_evt.part)]) else $error("low supply not aborted");
    cfg_resv_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5 |->
        reg_rdata[15:11] == 5'h00 && reg_rdata[7:0] == 8'h00) else $error("reserved set");
    pb_sample_a: assert property (pb_opcode_seen ##1 reg_rd && reg_addr == 4'h4 |=>
        reg_rdata[7] == $past(pb_free, 2)) else $error("buffer flag not latched");
endmodule : flash_status_props
bind flash_status_partition_regs flash_status_props #(
    .NUM_PART(NUM_PART), .TOP_PARAM(TOP_PARAM)) props_i (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_evt(ctrl_evt),
    .pb_opcode_seen(pb_opcode_seen), .pb_free(pb_free),
    .partition_ready(partition_ready), .plane_map(plane_map));
`default_nettype wire

// ===== dv/flash_ctrl_model.sv
// Write controller side: drives controller events and page buffer state
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_model (
    input wire logic core_clk,
    output var flash_status_pkg::ctrl_event_t ctrl_evt,
    output var logic pb_opcode_seen,
    output var logic pb_free
);
    // Idle values at time zero
    initial begin
        ctrl_evt = '0;
        pb_opcode_seen = 1'b0;
        pb_free = 1'b0;
    end
    // One-cycle event; start always precedes suspend, resume and done
    task automatic send(input flash_status_pkg::ctrl_event_t e);
        ctrl_evt <= e;
        @(posedge core_clk);
        ctrl_evt <= '0;
        #1;
    endtask : send
    // Opcode pulse; buffer level turned over once it is no longer sampled
    task automatic pb(input logic v);
        pb_opcode_seen <= 1'b1;
        pb_free <= v;
        @(posedge core_clk);
        pb_opcode_seen <= 1'b0;
        pb_free <= ~v;
        #1;
    endtask : pb
endmodule : flash_ctrl_model
`default_nettype wire

// ===== dv/tb_flash_status_partition_regs.sv
// Self-checking bench for the status and partition register block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_partition_regs;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    flash_status_pkg::ctrl_event_t ctrl_evt;
    logic pb_opcode_seen;
    logic pb_free;
    logic [3:0] partition_ready;
    flash_status_pkg::plane_map_t plane_map;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [11:0] map_exp [8] = '{12'h002, 12'h545, 12'h505, 12'hA47,
        12'h405, 12'h947, 12'h907, 12'hE49};
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #5 core_clk = ~core_clk;
    flash_status_partition_regs uut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ctrl_evt(ctrl_evt), .pb_opcode_seen(pb_opcode_seen), .pb_free(pb_free),
        .partition_ready(partition_ready), .plane_map(plane_map));
    flash_ctrl_model ctl (.core_clk(core_clk), .ctrl_evt(ctrl_evt),
        .pb_opcode_seen(pb_opcode_seen), .pb_free(pb_free));
    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, register access and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // Read one word and compare the unmasked bits
    task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rc
    function automatic flash_status_pkg::ctrl_event_t ev(input logic [7:0] f,
        input logic [1:0] p, input flash_status_pkg::op_kind_t k);
        return {f, p, k};
    endfunction : ev
    task automatic stop_test;
        $display("compared=%0d mismatches=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rc(i[3:0], 16'hFFFF, i < 5 ? 16'h0080 : (i == 5 ? 16'h0100 : 16'h0000));
        end
        chk({4'h0, plane_map}, {4'h0, map_exp[1]});
        $display("test reset done");
        ctl.send(ev(8'h80, 2'h1, flash_status_pkg::OP_ERASE));
        chk({12'h000, partition_ready}, 16'h000D);
        rc(4'h1, 16'h0080, 16'h0000);
        ctl.send(ev(8'h20, 2'h1, flash_status_pkg::OP_ERASE));
        rc(4'h1, 16'h0040, 16'h0040);
        ctl.send(ev(8'h10, 2'h1, flash_status_pkg::OP_ERASE));
        rc(4'h1, 16'h0040, 16'h0000);
        ctl.send(ev(8'h44, 2'h1, flash_status_pkg::OP_ERASE));
        rc(4'h1, 16'hFFFF, 16'h00A0);
        $display("test erase done");
        ctl.send(ev(8'h82, 2'h2, flash_status_pkg::OP_PROGRAM));
        chk({12'h000, partition_ready}, 16'h000B);
        ctl.send(ev(8'h20, 2'h2, flash_status_pkg::OP_PROGRAM));
        rc(4'h2, 16'h0004, 16'h0004);
        ctl.send(ev(8'h44, 2'h2, flash_status_pkg::OP_PROGRAM));
        wr(4'h2, 16'hFFFF);
        rc(4'h2, 16'hFFFF, 16'h0090);
        $display("test program done");
        ctl.send(ev(8'h82, 2'h3, flash_status_pkg::OP_PAGE_PROGRAM));
        chk({12'h000, partition_ready}, 16'h000F);
        rc(4'h3, 16'hFFFF, 16'h0088);
        ctl.send(ev(8'h81, 2'h0, flash_status_pkg::OP_ERASE));
        rc(4'h0, 16'hFFFF, 16'h0082);
        ctl.send(ev(8'h08, 2'h0, flash_status_pkg::OP_LOCK_CONFIG));
        rc(4'h0, 16'h00FE, 16'h00B2);
        wr(4'h6, 16'h0000);
        rc(4'h0, 16'hFFFF, 16'h00B2);
        wr(4'h6, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            rc(i[3:0], 16'hFFFF, 16'h0080);
        end
        $display("test flags done");
        ctl.pb(1'b0);
        rc(4'h4, 16'hFFFF, 16'h0000);
        ctl.pb(1'b1);
        rc(4'h4, 16'h0080, 16'h0080);
        $display("test buffer done");
        for (int i = 0; i < 8; i++) begin
            wr(4'h5, 16'hF8FF | {5'h00, i[2:0], 8'h00});
            rc(4'h5, 16'hFFFF, {5'h00, i[2:0], 8'h00});
            rc(4'h5, 16'h0700, {5'h00, i[2:0], 8'h00});
            chk({4'h0, plane_map}, {4'h0, map_exp[i]});
        end
        $display("test partitions done");
        stop_test();
    end
endmodule : tb_flash_status_partition_regs
`default_nettype wire
